/* File: src/irq_flag_gate.sv */
// flag gating: interrupt enable, stack select, priority level, arbitration
// assumes sequencer samples ack and trap strobes synchronously
//
// Functional notes
// RULE1 - global enable flag at 0 blocks maskable requests; at 1 allows them
// RULE2 - accepting any request clears the global enable flag
// RULE3 - stack select 0 picks handler stack, 1 picks task stack
// RULE4 - hardware accept or trap numbered 0 to 31 clears stack select
// RULE5 - processor priority level is three bits, levels 0 through 7
// RULE6 - accept only priority above current level; others stay pending
// RULE7 - reserved flag bits: write zero, read value undefined
// RULE8 - arbitrate 5 external, 23 internal, 4 software sources, 7 levels
// RULE9 - accept only with enable flag 1 and priority above level
`timescale 1ns/1ps
module irq_flag_gate
  import irq_gate_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input irq_gate_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  input wire logic [irq_gate_pkg::num_src-1:0][2:0] src_level,
  input wire logic [irq_gate_pkg::num_src-1:0] src_req,
  input wire logic trap_exec,
  input wire logic [5:0] trap_num,
  input wire logic ack_taken,
  output irq_gate_pkg::irq_ack_t irq_ack,
  output logic [2:0] accept_level,
  output logic task_stack_sel,
  output logic int_enable,
  output logic [2:0] processor_priority_level
);
  import irq_gate_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // arbitration: highest level wins, lowest index on tie
  logic [level_w-1:0] best_level;
  logic [src_w-1:0] best_src;
  logic best_valid;
  logic [level_w-1:0] lvl_c [num_src+1];
  logic [src_w-1:0] idx_c [num_src+1];
  logic vld_c [num_src+1];
  assign lvl_c[0] = '0;
  assign idx_c[0] = '0;
  assign vld_c[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < num_src; g++) begin : g_arb
      logic take;
      // level 0 is never a live request, leaving 7 usable levels [RULE8]
      assign take = src_req[g] && (src_level[g] != 3'h0) &&
                    (!vld_c[g] || (src_level[g] > lvl_c[g]));
      assign lvl_c[g+1] = take ? src_level[g] : lvl_c[g];
      assign idx_c[g+1] = take ? src_w'(g) : idx_c[g];
      assign vld_c[g+1] = take | vld_c[g];
    end
  endgenerate
  assign best_level = lvl_c[num_src];
  assign best_src = idx_c[num_src];
  assign best_valid = vld_c[num_src];

  ////////////////////////////////////////////////////////////////////////
  // flag state
  logic int_en_q, int_en_d;
  logic stk_sel_q, stk_sel_d;
  logic [level_w-1:0] level_q, level_d;
  logic accept;
  logic [15:0] flag_word;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] last_acc_q, last_acc_d;

  // request admitted only if enabled and strictly above level [RULE1] [RULE9]
  assign accept = int_en_q && best_valid && (best_level > level_q); // [RULE6]

  always_comb begin
    flag_word = reserved_read_value; // reserved bits read zero [RULE7]
    flag_word[flag_int_en_bit] = int_en_q;
    flag_word[flag_stk_sel_bit] = stk_sel_q;
    flag_word[flag_level_lsb +: level_w] = level_q; // [RULE5]
  end

  always_comb begin
    int_en_d = int_en_q;
    stk_sel_d = stk_sel_q;
    level_d = level_q;
    rdata_d = 16'h0000;
    last_acc_d = last_acc_q;
    if (reg_req.wr && reg_req.addr == flag_reg_offset) begin
      // reserved bits are dropped [RULE7]
      int_en_d = reg_req.wdata[flag_int_en_bit];
      stk_sel_d = reg_req.wdata[flag_stk_sel_bit];
      level_d = reg_req.wdata[flag_level_lsb +: level_w];
    end
    if (trap_exec && trap_num <= trap_vec_max) begin
      stk_sel_d = 1'b0; // [RULE4]
    end
    if (accept && ack_taken) begin
      int_en_d = 1'b0; // [RULE2]
      stk_sel_d = 1'b0; // [RULE4]
      last_acc_d = {8'h00, best_level, best_src};
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        flag_reg_offset: rdata_d = flag_word;
        pend_reg_offset: rdata_d = {8'h00, best_valid, 2'h0, best_src};
        accept_reg_offset: rdata_d = last_acc_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_en_q <= flag_reset_value[flag_int_en_bit];
      stk_sel_q <= flag_reset_value[flag_stk_sel_bit];
      level_q <= flag_reset_value[flag_level_lsb +: level_w];
      rdata_q <= 16'h0000;
      last_acc_q <= 16'h0000;
    end else if (clk_en) begin
      int_en_q <= int_en_d;
      stk_sel_q <= stk_sel_d;
      level_q <= level_d;
      rdata_q <= rdata_d;
      last_acc_q <= last_acc_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_ack.valid = accept;
  assign irq_ack.src = best_src;
  assign accept_level = best_level;
  assign task_stack_sel = stk_sel_q; // [RULE3]
  assign int_enable = int_en_q;
  assign processor_priority_level = level_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_blocked_when_disabled;
    @(posedge clk) disable iff (rst) !int_en_q |-> !irq_ack.valid;
  endproperty
  a_blocked_when_disabled: assert property (p_blocked_when_disabled) // [RULE1]
    else $error("accept while enable flag clear");

  sequence s_take;
    clk_en && irq_ack.valid && ack_taken;
  endsequence
  property p_accept_clears_en;
    @(posedge clk) disable iff (rst) s_take |=> !int_en_q && !stk_sel_q;
  endproperty
  a_accept_clears_en: assert property (p_accept_clears_en) // [RULE2]
    else $error("accept did not clear flags");

  property p_trap_clears_sel;
    @(posedge clk) disable iff (rst)
      clk_en && trap_exec && trap_num <= trap_vec_max |=> !task_stack_sel;
  endproperty
  a_trap_clears_sel: assert property (p_trap_clears_sel) // [RULE4]
    else $error("low trap did not clear stack select");

  property p_above_level;
    @(posedge clk) disable iff (rst)
      irq_ack.valid |-> accept_level > processor_priority_level;
  endproperty
  a_above_level: assert property (p_above_level) // [RULE6]
    else $error("accepted request not above level");

  property p_accept_cause;
    @(posedge clk) disable iff (rst)
      irq_ack.valid |-> int_enable && src_req[irq_ack.src];
  endproperty
  a_accept_cause: assert property (p_accept_cause) // [RULE9]
    else $error("accept without enable or request");

  property p_flag_write;
    @(posedge clk) disable iff (rst)
      clk_en && reg_req.wr && reg_req.addr == flag_reg_offset &&
      !irq_ack.valid && !trap_exec |=> processor_priority_level ==
      $past(reg_req.wdata[flag_level_lsb +: level_w]);
  endproperty
  a_flag_write: assert property (p_flag_write) // [RULE5]
    else $error("level write lost");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      clk_en && reg_req.rd && reg_req.addr == flag_reg_offset |=>
      (reg_rdata & ~flag_writable_mask) ==
      (reserved_read_value & ~flag_writable_mask);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE7]
    else $error("reserved bits nonzero");

  property p_stack_sel_out;
    @(posedge clk) disable iff (rst)
      clk_en && reg_req.wr && reg_req.addr == flag_reg_offset &&
      !irq_ack.valid && !trap_exec |=>
      task_stack_sel == $past(reg_req.wdata[flag_stk_sel_bit]);
  endproperty
  a_stack_sel_out: assert property (p_stack_sel_out) // [RULE3]
    else $error("stack select write lost");

  property p_trap_high_keeps;
    @(posedge clk) disable iff (rst)
      clk_en && trap_exec && trap_num > trap_vec_max && !reg_req.wr &&
      !(irq_ack.valid && ack_taken) |=> $stable(task_stack_sel);
  endproperty
  a_trap_high_keeps: assert property (p_trap_high_keeps) // [RULE4]
    else $error("high trap changed stack select");

  property p_live_level;
    @(posedge clk) disable iff (rst)
      irq_ack.valid |-> accept_level != 3'h0;
  endproperty
  a_live_level: assert property (p_live_level) // [RULE8]
    else $error("level zero request accepted");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      !clk_en |=> $stable(int_enable) && $stable(task_stack_sel) &&
      $stable(processor_priority_level) && $stable(reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
      clk_en && !reg_req.rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");
endmodule : irq_flag_gate

/* File: src/irq_gate_pkg.sv */
// package for the processor flag interrupt gating block
// assumes one clock domain and a plain register port
package irq_gate_pkg;
  localparam int num_ext_src = 5;
  localparam int num_int_src = 23;
  localparam int num_sw_src = 4;
  localparam int num_src = num_ext_src + num_int_src + num_sw_src;
  localparam int num_prio_levels = 7;
  localparam int level_w = 3;
  localparam int src_w = 5;
  localparam logic [5:0] trap_vec_max = 6'h1f;

  // flag register at offset 0, 16 bits
  localparam logic [1:0] flag_reg_offset = 2'h0;
  localparam logic [1:0] pend_reg_offset = 2'h1;
  localparam logic [1:0] accept_reg_offset = 2'h2;
  localparam int flag_int_en_bit = 6;
  localparam int flag_stk_sel_bit = 7;
  localparam int flag_level_lsb = 12;
  localparam logic [15:0] flag_writable_mask = 16'h70c0;
  localparam logic [15:0] flag_reset_value = 16'h0000;
  localparam logic [15:0] reserved_read_value = 16'h0000;

  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [level_w-1:0] level;
  } irq_req_t;

  typedef struct packed {
    logic valid;
    logic [src_w-1:0] src;
  } irq_ack_t;
endpackage : irq_gate_pkg

/* File: tb/irq_flag_gate_tb.sv */
// bench for the flag gating block
// assumes the sequencer model beside it
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module irq_flag_gate_tb;
  import irq_gate_pkg::*;
  logic clk, rst, clk_en, trap_exec, ack_taken, tss, ien;
  logic [5:0] trap_num;
  logic [7:0] wait_cyc;
  reg_req_t reg_req;
  logic [15:0] reg_rdata;
  logic [num_src-1:0][2:0] src_level;
  logic [num_src-1:0] src_req;
  irq_ack_t irq_ack;
  logic [2:0] acc_lvl, ppl;
  int bad_count, n_tests;
  irq_flag_gate u_dut (.clk(clk), .rst(rst), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .src_level(src_level),
    .src_req(src_req), .trap_exec(trap_exec), .trap_num(trap_num),
    .ack_taken(ack_taken), .irq_ack(irq_ack), .accept_level(acc_lvl),
    .task_stack_sel(tss), .int_enable(ien),
    .processor_priority_level(ppl));
  irq_seq_model u_seq (.clk(clk), .rst(rst), .irq_ack(irq_ack),
    .wait_cyc(wait_cyc), .ack_taken(ack_taken));
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk) reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) reg_req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk) reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) reg_req <= '0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic src(input int i, input logic [2:0] l);
    @(posedge clk) src_level[i] <= l;
    src_req[i] <= (l != 3'h0);
    @(posedge clk) #1;
  endtask : src
  task automatic trap(input logic [5:0] n, input logic e);
    @(posedge clk) trap_num <= n;
    trap_exec <= 1'b1;
    @(posedge clk) trap_exec <= 1'b0;
    #1 `CHK(tss, e)
  endtask : trap
  ////////////////////////////////////////////////////////////////////////
  task automatic t_gate;
    src(2, 3'h5);
    wr(2'h0, 16'h3000);
    `CHK(irq_ack.valid, 1'b0)
    wr(2'h0, 16'h3040);
    `CHK(irq_ack.valid, 1'b1)
    `CHK(irq_ack.src, 5'h02)
    wr(2'h0, 16'h5040);
    `CHK(irq_ack.valid, 1'b0)
    wr(2'h0, 16'h40c0);
    `CHK(tss, 1'b1)
    @(posedge clk) wait_cyc <= 8'h02;
    for (int k = 0; k < 20 && ien; k++) @(posedge clk) #1;
    #1 `CHK(ien, 1'b0)
    `CHK(tss, 1'b0)
    `CHK(irq_ack.valid, 1'b0)
    rd(2'h2, 16'h00a2);
    @(posedge clk) wait_cyc <= 8'hff;
    src(2, 3'h0);
    $display("gate test done");
  endtask : t_gate
  task automatic t_stack;
    wr(2'h0, 16'h0080);
    `CHK(tss, 1'b1)
    rd(2'h0, 16'h0080);
    trap(6'h20, 1'b1);
    trap(6'h1f, 1'b0);
    wr(2'h0, 16'h70c0);
    `CHK(ppl, 3'h7)
    rd(2'h0, 16'h70c0);
    src(3, 3'h7);
    `CHK(irq_ack.valid, 1'b0)
    src(3, 3'h0);
    $display("stack test done");
  endtask : t_stack
  task automatic t_arb;
    wr(2'h0, 16'h0040);
    for (int i = 0; i < num_src; i++) begin
      src(i, 3'h1);
      `CHK(irq_ack.src, i[4:0])
      src(i, 3'h0);
    end
    src(9, 3'h3);
    src(4, 3'h3);
    `CHK(irq_ack.src, 5'h04)
    src(20, 3'h6);
    `CHK(irq_ack.src, 5'h14)
    `CHK(acc_lvl, 3'h6)
    $display("arbitration test done");
  endtask : t_arb
  task automatic t_freeze;
    @(posedge clk) clk_en <= 1'b0;
    wr(2'h0, 16'h0000);
    `CHK({ien, tss, ppl}, 5'h1f)
    rd(2'h0, 16'h0000);
    @(posedge clk) clk_en <= 1'b1;
    rd(2'h0, 16'h70c0);
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_regs;
    wr(2'h1, 16'h0000);
    wr(2'h2, 16'h0000);
    `CHK({ien, tss, ppl}, 5'h1f)
    src(7, 3'h2);
    `CHK(irq_ack.valid, 1'b0)
    rd(2'h1, 16'h0087);
    rd(2'h3, 16'h0000);
    src(7, 3'h0);
    rd(2'h1, 16'h0000);
    $display("register test done");
  endtask : t_regs
  task automatic t_reset;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1 `CHK({ien, tss, ppl, reg_rdata}, 21'h0)
    rd(2'h2, 16'h0000);
    $display("reset test done");
  endtask : t_reset
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    bad_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    {trap_exec, trap_num, reg_req, src_level, src_req} = '0;
    wait_cyc = 8'hff;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1 `CHK({ien, tss, ppl, irq_ack.valid}, 6'h00)
    t_gate();
    t_stack();
    t_freeze();
    t_regs();
    t_reset();
    t_arb();
    print_verdict();
  end
endmodule : irq_flag_gate_tb

/* File: tb/irq_seq_model.sv */
// sequencer stand-in: takes an offered accept after a set wait
// assumes irq_ack is combinational from the gate
`timescale 1ns/1ps
module irq_seq_model
  import irq_gate_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input irq_gate_pkg::irq_ack_t irq_ack,
  input wire logic [7:0] wait_cyc,
  output logic ack_taken
);
  logic [7:0] cnt_q, cnt_d;
  always_comb begin
    cnt_d = (irq_ack.valid && !ack_taken) ? cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk) begin
    if (rst) cnt_q <= 8'h00;
    else cnt_q <= cnt_d;
  end
  assign ack_taken = irq_ack.valid && (cnt_q >= wait_cyc);
endmodule : irq_seq_model
